/* File: hdl/sspt_pkg.sv */
// Constants for the second synchronous serial port: register map, field layout,
// reset values and enable strap positions.
// Assumes a 16-bit on-chip peripheral bus with 24-bit byte addresses.
package sspt_pkg;
  // Decode window of the port
  localparam logic [23:0] WIN_BASE = 24'h00e800;
  localparam logic [23:0] WIN_LAST = 24'h00e8ff;
  // Register byte addresses
  localparam logic [23:0] OFS_CON  = 24'h00e800;
  localparam logic [23:0] OFS_BAUD = 24'h00e802;
  localparam logic [23:0] OFS_TXB  = 24'h00e804;
  localparam logic [23:0] OFS_RXB  = 24'h00e806;
  // Control view bit positions (width field sits in bits 3..0)
  localparam int CB_HB   = 4;
  localparam int CB_PH   = 5;
  localparam int CB_PO   = 6;
  localparam int CB_TEN  = 8;
  localparam int CB_REN  = 9;
  localparam int CB_PEN  = 10;
  localparam int CB_BEN  = 11;
  localparam int CB_AREN = 12;
  localparam int CB_MS   = 14;
  localparam int CB_EN   = 15;
  // Status view bit positions (bit count sits in bits 3..0)
  localparam int SB_TE  = 8;
  localparam int SB_RE  = 9;
  localparam int SB_PE  = 10;
  localparam int SB_BE  = 11;
  localparam int SB_BSY = 12;
  // Enable bits in the system and peripheral enable registers
  localparam int SYS_PBUS_BIT = 2;
  localparam int PERX_BIT     = 8;
  // Reset values and writable bits of the control view
  localparam logic [15:0] CON_RST   = 16'h0000;
  localparam logic [15:0] BAUD_RST  = 16'h0000;
  localparam logic [15:0] CON_WMASK = 16'hdf7f;
  // Cycles after a latching edge in which a data change is a phase error
  localparam logic [1:0]  PE_WIN    = 2'h2;
  // Core clock rate
  localparam int CORE_CLK_MHZ = 250;
  // Transfer engine states
  typedef enum logic [1:0] {
    S_IDLE  = 2'b01,
    S_SHIFT = 2'b10
  } sspt_state_t;
endpackage : sspt_pkg

/* File: hdl/sspt_port.sv */
// Second synchronous serial port: transmit FIFO and the port engine with its
// register slave. Assumes pins reach it through port logic that resolves the
// enables; enable register bits come from same-clock logic.
`timescale 1ns/1ps

// Transmit holding FIFO; DEPTH must be a power of two so pointers wrap freely
module sspt_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;  // Word storage
    logic [AW-1:0]           wp;   // Write pointer
    logic [AW-1:0]           rp;   // Read pointer
    logic [AW:0]             cnt;  // Fill level
  } sspt_fifo_t;
  sspt_fifo_t st_r;
  sspt_fifo_t st_nxt;
  logic       push;
  logic       pop;

  // Honest full and empty from the fill level
  assign in_ready  = st_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_r.cnt != '0;
  assign out_data  = st_r.mem[st_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next state of storage and pointers
  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp           = st_r.wp + 1'b1;
    end
    if (pop)
      st_nxt.rp = st_r.rp + 1'b1;
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule : sspt_fifo

module sspt_port #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [15:0] system_config_reg,
  input  wire logic [15:0] periph_enable_reg,
  input  wire logic        open_drain_sel,
  input  wire logic        bus_sel,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [23:0] bus_addr,
  input  wire logic [15:0] bus_wdata,
  output logic [15:0]      bus_rdata,
  output logic             bus_ack,
  output logic             txbuf_ready,
  input  wire logic        shift_clock_line_i,
  output logic             shift_clock_line_o,
  output logic             shift_clock_line_oe_n,
  input  wire logic        master_out_line_i,
  output logic             master_out_line_o,
  output logic             master_out_line_oe_n,
  input  wire logic        master_in_line_i,
  output logic             master_in_line_o,
  output logic             master_in_line_oe_n,
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             err_irq
);
  typedef struct packed {
    sspt_pkg::sspt_state_t state;  // Transfer engine state
    logic [15:0] con;       // Control bits
    logic [15:0] baud_rl;   // Baud reload value
    logic [15:0] baud_cnt;  // Baud down counter
    logic [15:0] sh;        // Transmit shift register
    logic [15:0] rxsh;      // Receive shift register
    logic [15:0] rxbuf;     // Receive holding buffer
    logic [15:0] rdata;     // Bus read data
    logic [4:0]  lat;       // Bits latched in this frame
    logic [1:0]  pe_win;    // Phase check window after a latch
    logic [18:0] per;       // Slave clock period meter
    logic te, re, pe, be;   // Error flags
    logic rx_full, loaded, sck, chg_d, ack, tx_irq, rx_irq, err_irq, txrdy;
    logic sck_s1, sck_s2, sck_s3, mo_s1, mo_s2, mo_s3, mi_s1, mi_s2, mi_s3;
    logic mo_o, mi_o, sck_oe_n, mo_oe_n, mi_oe_n;
  } sspt_regs_t;

  localparam sspt_regs_t ST_RST = '{state: sspt_pkg::S_IDLE, con: sspt_pkg::CON_RST,
    baud_rl: sspt_pkg::BAUD_RST, mo_o: 1'b1, mi_o: 1'b1, sck_oe_n: 1'b1,
    mo_oe_n: 1'b1, mi_oe_n: 1'b1, default: '0};

  sspt_regs_t  st_r;
  sspt_regs_t  st_nxt;
  logic        op_en, in_win, wr_con, wr_baud, wr_txb, rd_rxb;
  logic        en, ms, ph, po, hb, tick, lead, trail, latch_ev, shift_ev;
  logic        din, chg, start, done, pop, bit_o;
  logic        te_set, re_set, pe_set, be_set;
  logic [4:0]  w;
  logic [15:0] msk, rx_n, stat;
  logic [18:0] lim;
  logic        f_iready, f_ovalid;
  logic [15:0] f_odata;

  // Transmit words queue here while the shift register is busy
  sspt_fifo #(
    .W     (16),
    .DEPTH (FIFO_DEPTH)
  ) u_txq (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (wr_txb),
    .in_ready  (f_iready),
    .in_data   (bus_wdata),
    .out_valid (f_ovalid),
    .out_ready (pop),
    .out_data  (f_odata)
  );

  // Decode of the window and of the mapped words
  assign in_win  = bus_sel && bus_addr >= sspt_pkg::WIN_BASE
                   && bus_addr <= sspt_pkg::WIN_LAST;
  assign wr_con  = in_win && bus_wr && bus_addr == sspt_pkg::OFS_CON;
  assign wr_baud = in_win && bus_wr && bus_addr == sspt_pkg::OFS_BAUD;
  assign wr_txb  = in_win && bus_wr && bus_addr == sspt_pkg::OFS_TXB;
  assign rd_rxb  = in_win && bus_rd && bus_addr == sspt_pkg::OFS_RXB;
  // Control fields
  assign en = st_r.con[sspt_pkg::CB_EN];
  assign ms = st_r.con[sspt_pkg::CB_MS];
  assign ph = st_r.con[sspt_pkg::CB_PH];
  assign po = st_r.con[sspt_pkg::CB_PO];
  assign hb = st_r.con[sspt_pkg::CB_HB];
  assign w  = {1'b0, st_r.con[3:0]} + 5'h1;
  assign msk = 16'hffff >> (5'h10 - w);
  assign op_en = en && system_config_reg[sspt_pkg::SYS_PBUS_BIT]
                 && periph_enable_reg[sspt_pkg::PERX_BIT];

  // Engine, baud generator, error checks and register slave
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.tx_irq = 1'b0;
    st_nxt.rx_irq = 1'b0;
    st_nxt.err_irq = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    tick = 1'b0;
    start = 1'b0;
    done = 1'b0;
    te_set = 1'b0;
    re_set = 1'b0;
    pe_set = 1'b0;
    be_set = 1'b0;
    rx_n = st_r.rxsh;
    lim = 19'(st_r.baud_rl) + 19'h1;
    // Two-stage synchronisers, third stage only for edge detection
    st_nxt.sck_s1 = shift_clock_line_i;
    st_nxt.sck_s2 = st_r.sck_s1;
    st_nxt.sck_s3 = st_r.sck_s2;
    st_nxt.mo_s1 = master_out_line_i;
    st_nxt.mo_s2 = st_r.mo_s1;
    st_nxt.mo_s3 = st_r.mo_s2;
    st_nxt.mi_s1 = master_in_line_i;
    st_nxt.mi_s2 = st_r.mi_s1;
    st_nxt.mi_s3 = st_r.mi_s2;
    // Master listens on the in line, slave on the out line
    din = ms ? st_r.mi_s2 : st_r.mo_s2;
    chg = ms ? (st_r.mi_s2 != st_r.mi_s3) : (st_r.mo_s2 != st_r.mo_s3);
    st_nxt.chg_d = chg;
    // Half-bit tick every reload+1 cycles; stopped counter shows reload
    if (op_en && st_r.baud_cnt == 16'h0)
    begin
      st_nxt.baud_cnt = st_r.baud_rl;
      tick = 1'b1;
    end
    else if (op_en)
      st_nxt.baud_cnt = st_r.baud_cnt - 16'h1;
    else
      st_nxt.baud_cnt = st_r.baud_rl;
    // Edge sources: own ticks as master, synchronised pin as slave
    if (ms && st_r.state == sspt_pkg::S_SHIFT && tick)
    begin
      st_nxt.sck = ~st_r.sck;
      lead = st_r.sck == po;
      trail = !lead;
    end
    else if (!ms && op_en && st_r.sck_s2 != st_r.sck_s3)
    begin
      lead = st_r.sck_s2 != po;
      trail = !lead;
    end
    latch_ev = ph ? lead : trail;
    shift_ev = ph ? trail : lead;
    pop = op_en && st_r.state == sspt_pkg::S_IDLE && !st_r.loaded && f_ovalid
          && !lead;
    unique case (st_r.state)
      sspt_pkg::S_IDLE:
      begin
        // Preload the shift register from the holding FIFO
        if (pop)
        begin
          st_nxt.sh = f_odata;
          st_nxt.loaded = 1'b1;
          st_nxt.tx_irq = 1'b1;
        end
        if (op_en && ((ms && st_r.loaded) || (!ms && lead)))
        begin
          start = 1'b1;
          te_set = !ms && !st_r.loaded;  // Old contents go out
          st_nxt.loaded = 1'b0;
          st_nxt.lat = 5'h0;
          st_nxt.per = 19'h0;
          st_nxt.state = sspt_pkg::S_SHIFT;
        end
      end
      sspt_pkg::S_SHIFT:
      begin
        st_nxt.per = st_r.per + 19'h1;
        if (!ms && lead)
        begin
          // Slave period check: more than twice or less than half
          be_set = st_r.per > (lim << 2) || st_r.per < lim;
          st_nxt.per = 19'h0;
        end
      end
    endcase
    // Shifting and latching, also on the slave edge that opens a frame
    if (st_r.state == sspt_pkg::S_SHIFT || (start && !ms))
    begin
      if (latch_ev)
      begin
        rx_n = hb ? {st_r.rxsh[14:0], din} : {din, st_r.rxsh[15:1]};
        st_nxt.lat = st_r.lat + 5'h1;
        st_nxt.pe_win = sspt_pkg::PE_WIN;
        pe_set = chg || st_r.chg_d;
      end
      else if (st_r.pe_win != 2'h0)
      begin
        st_nxt.pe_win = st_r.pe_win - 2'h1;
        pe_set = chg;
      end
      // In phase 0 the first bit is already on the line before the first edge
      if (shift_ev && !(!ph && st_r.lat == 5'h0))
        st_nxt.sh = hb ? {st_r.sh[14:0], 1'b0} : {1'b0, st_r.sh[15:1]};
      st_nxt.rxsh = rx_n;
      done = trail && st_nxt.lat == w;
    end
    if (done)
    begin
      st_nxt.rxbuf = hb ? (rx_n & msk) : (rx_n >> (5'h10 - w));
      st_nxt.sh = st_nxt.rxbuf;
      st_nxt.rx_irq = 1'b1;
      st_nxt.state = sspt_pkg::S_IDLE;
      re_set = st_r.rx_full && !rd_rxb;
    end
    // Automatic reset on a baud rate error, and stop while disabled
    if (!op_en || (be_set && st_r.con[sspt_pkg::CB_AREN]))
    begin
      st_nxt.state = sspt_pkg::S_IDLE;
      st_nxt.lat = 5'h0;
      st_nxt.sck = po;
    end
    // Receive buffer: a completion in the read cycle keeps it full
    st_nxt.rx_full = (rd_rxb ? 1'b0 : st_r.rx_full) | done;
    // Error flags: software writes while enabled, a new event wins
    st_nxt.te = ((wr_con && en) ? bus_wdata[sspt_pkg::SB_TE] : st_r.te) | te_set;
    st_nxt.re = ((wr_con && en) ? bus_wdata[sspt_pkg::SB_RE] : st_r.re) | re_set;
    st_nxt.pe = ((wr_con && en) ? bus_wdata[sspt_pkg::SB_PE] : st_r.pe) | pe_set;
    st_nxt.be = ((wr_con && en) ? bus_wdata[sspt_pkg::SB_BE] : st_r.be) | be_set;
    st_nxt.err_irq = (te_set && st_r.con[sspt_pkg::CB_TEN])
                     || (re_set && st_r.con[sspt_pkg::CB_REN])
                     || (pe_set && st_r.con[sspt_pkg::CB_PEN])
                     || (be_set && st_r.con[sspt_pkg::CB_BEN]);
    // Control writes: full set when disabled, only enable and mode when running
    if (wr_con && !en)
      st_nxt.con = bus_wdata & sspt_pkg::CON_WMASK;
    else if (wr_con)
    begin
      st_nxt.con[sspt_pkg::CB_EN] = bus_wdata[sspt_pkg::CB_EN];
      st_nxt.con[sspt_pkg::CB_MS] = bus_wdata[sspt_pkg::CB_MS];
    end
    // Reload may only change while disabled; writes when enabled are dropped
    if (wr_baud && !en)
      st_nxt.baud_rl = bus_wdata;
    // Status view of the control address
    stat = 16'h0;
    stat[sspt_pkg::CB_EN] = 1'b1;
    stat[sspt_pkg::CB_MS] = ms;
    stat[sspt_pkg::SB_BSY] = st_r.state == sspt_pkg::S_SHIFT;
    stat[sspt_pkg::SB_BE] = st_r.be;
    stat[sspt_pkg::SB_PE] = st_r.pe;
    stat[sspt_pkg::SB_RE] = st_r.re;
    stat[sspt_pkg::SB_TE] = st_r.te;
    stat[3:0] = st_r.lat[3:0];
    // Read mux; unmapped words in the window read zero
    if (in_win && (bus_rd || bus_wr))
    begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = 16'h0;
      if (bus_rd && bus_addr == sspt_pkg::OFS_CON)
        st_nxt.rdata = en ? stat : st_r.con;
      else if (bus_rd && bus_addr == sspt_pkg::OFS_BAUD)
        st_nxt.rdata = en ? st_r.baud_cnt : st_r.baud_rl;
      else if (rd_rxb)
        st_nxt.rdata = st_r.rxbuf;
    end
    st_nxt.txrdy = f_iready;
    // Pins follow the next shift value so data meets the registered clock edge;
    // on the closing edge they hold, so the far side keeps hold time on the last bit
    if (done)
      bit_o = ms ? st_r.mo_o : st_r.mi_o;
    else
      bit_o = hb ? st_nxt.sh[4'(w - 5'h1)] : st_nxt.sh[0];
    st_nxt.mo_o = (op_en && ms) ? bit_o : 1'b1;
    st_nxt.mi_o = (op_en && !ms) ? bit_o : 1'b1;
    st_nxt.sck_oe_n = !(op_en && ms);
    // Open drain drives only zeros so a shared half-duplex line works
    st_nxt.mo_oe_n = (op_en && ms) ? (open_drain_sel && bit_o) : 1'b1;
    st_nxt.mi_oe_n = (op_en && !ms) ? (open_drain_sel && bit_o) : 1'b1;
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (reset)
      st_r <= ST_RST;
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign bus_rdata             = st_r.rdata;
  assign bus_ack               = st_r.ack;
  assign txbuf_ready           = st_r.txrdy;
  assign shift_clock_line_o    = st_r.sck;
  assign shift_clock_line_oe_n = st_r.sck_oe_n;
  assign master_out_line_o     = st_r.mo_o;
  assign master_out_line_oe_n  = st_r.mo_oe_n;
  assign master_in_line_o      = st_r.mi_o;
  assign master_in_line_oe_n   = st_r.mi_oe_n;
  assign tx_irq                = st_r.tx_irq;
  assign rx_irq                = st_r.rx_irq;
  assign err_irq               = st_r.err_irq;

  // Checks on the engine
  property p_win;
    @(posedge core_clk) disable iff (reset) bus_ack |-> $past(in_win);
  endproperty
  a_win: assert property (p_win) else $error("ack outside window");
  property p_en;
    @(posedge core_clk) disable iff (reset)
      st_r.state == sspt_pkg::S_SHIFT |-> $past(op_en);
  endproperty
  a_en: assert property (p_en) else $error("shifting while not enabled");
  property p_mclk;
    @(posedge core_clk) disable iff (reset) $past(op_en && ms) |-> !shift_clock_line_oe_n;
  endproperty
  a_mclk: assert property (p_mclk) else $error("master not driving clock");
  property p_sdir;
    @(posedge core_clk) disable iff (reset)
      $past(op_en && !ms) |-> shift_clock_line_oe_n && master_out_line_oe_n;
  endproperty
  a_sdir: assert property (p_sdir) else $error("slave drives master lines");
  property p_pol;
    @(posedge core_clk) disable iff (reset) $past(!op_en) |-> st_r.sck == $past(po);
  endproperty
  a_pol: assert property (p_pol) else $error("idle clock level wrong");
  property p_rd9;
    @(posedge core_clk) disable iff (reset)
      $past(in_win && bus_rd && bus_addr == sspt_pkg::OFS_CON && !en)
      |-> bus_rdata == $past(st_r.con);
  endproperty
  a_rd9: assert property (p_rd9) else $error("control view wrong");
  property p_rd10;
    @(posedge core_clk) disable iff (reset)
      $past(in_win && bus_rd && bus_addr == sspt_pkg::OFS_CON && en)
      |-> bus_rdata[15] && bus_rdata[12] == $past(st_r.state == sspt_pkg::S_SHIFT);
  endproperty
  a_rd10: assert property (p_rd10) else $error("status view wrong");
  property p_baud;
    @(posedge core_clk) disable iff (reset)
      op_en && st_r.baud_cnt == 16'h0 |=> st_r.baud_cnt == $past(st_r.baud_rl);
  endproperty
  a_baud: assert property (p_baud) else $error("baud reload missed");
  property p_load;
    @(posedge core_clk) disable iff (reset) $past(pop) |-> st_r.loaded && st_r.tx_irq;
  endproperty
  a_load: assert property (p_load) else $error("holding word not loaded");
  property p_done;
    @(posedge core_clk) disable iff (reset)
      rx_irq |-> st_r.rx_full && st_r.lat == $past(w);
  endproperty
  a_done: assert property (p_done) else $error("frame length wrong");
endmodule : sspt_port

/* File: tb/sspt_spi_peer.sv */
// Peer slave model standing on the serial pins while the port is master.
// Assumes the bench resolves the pin levels and raises clr before each frame.
`timescale 1ns/1ps
module sspt_spi_peer (
  input  wire logic        sck,     // Resolved shift clock line
  input  wire logic        mosi,    // Resolved master out line
  input  wire logic        po,      // Idle clock level in use
  input  wire logic        ph,      // 1 = latch on the leading edge
  input  wire logic        clr,     // Rising edge starts a fresh frame
  input  wire logic [15:0] tx_pat,  // Answer word, first bit is bit 15
  input  wire logic [7:0]  lag,     // Answer delay in ns, for a slow peer
  output logic             miso,    // Master in line as driven by the peer
  output logic [15:0]      rx_bits, // Bits seen, latest one in bit 0
  output logic [4:0]       nbits    // Bits latched in this frame
);
  int idx; // Index of the answer bit now on the line
  // Latch on one edge kind and shift on the other; the first shift edge that
  // comes before any latch is skipped, since bit 15 already sits on the line
  always @(sck or posedge clr)
  begin
    if (clr)
    begin
      idx = 0;
      nbits <= 5'h00;
      rx_bits <= 16'h0000;
      miso <= tx_pat[15];
    end
    else if ((sck == ~po) == ph)
    begin
      rx_bits <= {rx_bits[14:0], mosi};
      nbits <= nbits + 5'h01;
    end
    else if (nbits != 5'h00 && idx < 15)
    begin
      idx = idx + 1;
      miso <= #(lag) tx_pat[15-idx];
    end
  end
endmodule : sspt_spi_peer

/* File: tb/sspt_port_tb.sv */
// Bench for the second serial port: registers, both views, clock modes, FIFO.
// Assumes the peer slave model sits on the resolved pins.
`timescale 1ns/1ps
module sspt_port_tb;
  logic        core_clk  = 1'b0;     // Core clock
  logic        reset     = 1'b1;     // Synchronous reset
  logic [15:0] sys_cfg   = 16'h0004; // Bus enable strap
  logic [15:0] per_en    = 16'h0100; // Port enable strap
  logic        bus_sel   = 1'b0;     // Bus request lines
  logic        bus_wr    = 1'b0;
  logic        bus_rd    = 1'b0;
  logic [23:0] bus_addr  = 24'h000000;
  logic [15:0] bus_wdata = 16'h0000;
  logic        peer_po   = 1'b0;     // Peer clock mode
  logic        peer_ph   = 1'b0;
  logic        peer_clr  = 1'b0;     // Peer frame restart
  logic [15:0] peer_pat  = 16'h0000; // Peer answer word
  logic [7:0]  peer_lag  = 8'h00;    // Peer answer delay
  logic        od_sel    = 1'b0;     // Open drain data outputs
  wire  [15:0] bus_rdata, peer_rx;
  wire  [4:0]  peer_n;
  wire         bus_ack, txbuf_ready, tx_irq, rx_irq, err_irq, peer_miso;
  wire         sck_o, sck_oe_n, mo_o, mo_oe_n, mi_o, mi_oe_n;
  int          n_errors = 0;
  int          comparisons = 0;
  // A released clock stands at its idle level; a released out line is pulled up, a released in line follows the peer
  wire sck_w = sck_oe_n ? peer_po : sck_o;
  wire mo_w  = mo_oe_n ? 1'b1 : mo_o;
  wire mi_w  = mi_oe_n ? peer_miso : mi_o;
  // 4 ns period
  always #2 core_clk = ~core_clk;
  sspt_port #(.FIFO_DEPTH(16)) sspt_port_inst (.core_clk(core_clk), .reset(reset),
    .system_config_reg(sys_cfg), .periph_enable_reg(per_en), .open_drain_sel(od_sel),
    .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .txbuf_ready(txbuf_ready), .shift_clock_line_i(sck_w), .shift_clock_line_o(sck_o),
    .shift_clock_line_oe_n(sck_oe_n), .master_out_line_i(mo_w), .master_out_line_o(mo_o),
    .master_out_line_oe_n(mo_oe_n), .master_in_line_i(mi_w), .master_in_line_o(mi_o),
    .master_in_line_oe_n(mi_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
  sspt_spi_peer sspt_spi_peer_inst (.sck(sck_w), .mosi(mo_w), .po(peer_po), .ph(peer_ph),
    .clr(peer_clr), .tx_pat(peer_pat), .lag(peer_lag), .miso(peer_miso),
    .rx_bits(peer_rx), .nbits(peer_n));
  // Verdict and end of run
  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // Value compare
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One access: strobe for one cycle, answer looked at in the cycle after
  task automatic bus(input logic w, input logic [23:0] a, input logic [15:0] d,
                     output logic [15:0] q, output logic k);
    @(negedge core_clk);
    bus_sel = 1'b1;
    bus_wr = w;
    bus_rd = ~w;
    bus_addr = a;
    bus_wdata = d;
    @(negedge core_clk);
    bus_sel = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    k = bus_ack;
    q = bus_rdata;
  endtask : bus
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic        k;
    bus(1'b1, a, d, q, k);
    chk("write ack", 16'h0001, {15'h0, k});
  endtask : wr
  task automatic rd(input logic [23:0] a, output logic [15:0] q);
    logic k;
    bus(1'b0, a, 16'h0000, q, k);
    chk("read ack", 16'h0001, {15'h0, k});
  endtask : rd
  // Bit reversal of the low w bits
  function automatic logic [15:0] rev(input logic [15:0] x, input int w);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < w; i++)
      r[w-1-i] = x[i];
    return r;
  endfunction : rev
  // Reset values, window edges and the control view write mask
  task automatic t_regs();
    logic [15:0] q;
    logic        k;
    rd(sspt_pkg::OFS_CON, q);
    chk("con reset", sspt_pkg::CON_RST, q);
    rd(sspt_pkg::OFS_BAUD, q);
    chk("baud reset", sspt_pkg::BAUD_RST, q);
    chk("idle enables", 16'h0007, {13'h0, sck_oe_n, mo_oe_n, mi_oe_n});
    bus(1'b0, 24'h00e7fe, 16'h0000, q, k);
    chk("below window", 16'h0000, {15'h0, k});
    bus(1'b1, 24'h00e900, 16'h0000, q, k);
    chk("above window", 16'h0000, {15'h0, k});
    rd(24'h00e8fe, q);
    chk("unmapped word", 16'h0000, q);
    wr(sspt_pkg::OFS_CON, 16'h7fff);
    rd(sspt_pkg::OFS_CON, q);
    chk("control view", 16'h7fff & sspt_pkg::CON_WMASK, q);
    wr(sspt_pkg::OFS_CON, 16'h0000);
  endtask : t_regs
  // One master frame in a given mode; half bit is baud+1 = 4 cycles
  task automatic t_xfer(input logic po, input logic ph, input logic hb, input logic [3:0] wm1,
                        input logic [15:0] word, input logic [15:0] pat, input logic [7:0] lag);
    logic [15:0] ctl, q, m, s;
    logic        prv;
    int          w, tg, gap;
    w = int'(wm1) + 1;
    m = 16'hffff >> (16 - w);
    s = pat >> (16 - w);
    ctl = 16'h4000 | {9'h000, po, ph, hb, wm1};
    peer_clr = 1'b0;
    @(negedge core_clk);
    peer_po = po;
    peer_ph = ph;
    peer_pat = pat;
    peer_lag = lag;
    peer_clr = 1'b1;
    wr(sspt_pkg::OFS_CON, ctl);
    wr(sspt_pkg::OFS_BAUD, 16'h0003);
    wr(sspt_pkg::OFS_CON, ctl | 16'h8000);
    peer_clr = 1'b0;
    @(negedge core_clk);
    chk("clock idle level", {15'h0, po}, {15'h0, sck_o});
    chk("master drives clock", 16'h0000, {15'h0, sck_oe_n});
    wr(sspt_pkg::OFS_TXB, word);
    tg = 0;
    gap = 0;
    prv = sck_w;
    for (int i = 0; i < 1000 && rx_irq !== 1'b1; i++)
    begin
      @(negedge core_clk);
      gap++;
      if (sck_w !== prv)
      begin
        if (tg > 0)
          chk("half bit", 16'h0004, 16'(gap));
        tg++;
        gap = 0;
        prv = sck_w;
      end
    end
    chk("clock edges", 16'(2 * w), 16'(tg));
    chk("peer word", hb ? word & m : rev(word, w), peer_rx);
    rd(sspt_pkg::OFS_RXB, q);
    chk("rx word", hb ? s : rev(s, w), q);
    rd(sspt_pkg::OFS_CON, q);
    chk("status view", 16'hc000, q & 16'hc000);
    wr(sspt_pkg::OFS_CON, 16'h0000);
  endtask : t_xfer
  // Fill the FIFO until it refuses, then drain it once both straps are set
  task automatic t_fifo();
    int cnt, irqs, txs, errs;
    cnt = 0;
    per_en = 16'h0000;
    wr(sspt_pkg::OFS_BAUD, 16'h0000);
    wr(sspt_pkg::OFS_CON, 16'h4201);
    wr(sspt_pkg::OFS_CON, 16'hc201);
    for (int i = 0; i < 20; i++)
    begin
      @(negedge core_clk);
      if (txbuf_ready === 1'b1)
      begin
        wr(sspt_pkg::OFS_TXB, 16'(i));
        cnt++;
      end
    end
    chk("fifo words", 16'h0010, 16'(cnt));
    for (int k = 0; k < 3; k++)
    begin
      sys_cfg = (k == 0) ? 16'h0000 : 16'h0004;
      per_en = (k == 1) ? 16'h0000 : 16'h0100;
      irqs = 0;
      txs = 0;
      errs = 0;
      repeat (1200)
      begin
        @(negedge core_clk);
        if (rx_irq === 1'b1)
          irqs++;
        if (tx_irq === 1'b1)
          txs++;
        if (err_irq === 1'b1)
          errs++;
      end
      chk("frames sent", (k == 2) ? 16'h0010 : 16'h0000, 16'(irqs));
      chk("words moved", (k == 2) ? 16'h0010 : 16'h0000, 16'(txs));
      chk("error pulses", (k == 2) ? 16'h000f : 16'h0000, 16'(errs));
    end
    chk("fifo drained", 16'h0001, {15'h0, txbuf_ready});
    wr(sspt_pkg::OFS_CON, 16'h0000);
  endtask : t_fifo
  // Slave frames on a bench-toggled clock: one with a queued word, one without,
  // which must raise a transmit error; open drain releases the line for ones
  task automatic t_slave();
    logic [15:0] q;
    int          rxn, txn, ern;
    peer_po = 1'b0;
    od_sel = 1'b1;
    wr(sspt_pkg::OFS_BAUD, 16'h0003);
    wr(sspt_pkg::OFS_CON, 16'h0113);
    wr(sspt_pkg::OFS_CON, 16'h8113);
    for (int f = 0; f < 2; f++)
    begin
      rxn = 0;
      txn = 0;
      ern = 0;
      if (f == 0)
        wr(sspt_pkg::OFS_TXB, 16'h0005);
      for (int i = 0; i < 48; i++)
      begin
        @(negedge core_clk);
        if (f == 0 && i == 3)
          chk("slave pins", 16'h000c, {12'h0, sck_oe_n, mo_oe_n, mi_oe_n, mi_o});
        if (f == 0 && i == 47)
          chk("open drain one", 16'h000f, {12'h0, sck_oe_n, mo_oe_n, mi_oe_n, mi_o});
        if (i >= 4 && i < 36 && i % 4 == 0)
          peer_po = ~peer_po;
        rxn += int'(rx_irq === 1'b1);
        txn += int'(tx_irq === 1'b1);
        ern += int'(err_irq === 1'b1);
      end
      chk("slave frames", 16'h0001, 16'(rxn));
      chk("slave loads", (f == 0) ? 16'h0001 : 16'h0000, 16'(txn));
      chk("slave err pulses", (f == 1) ? 16'h0001 : 16'h0000, 16'(ern));
      rd(sspt_pkg::OFS_RXB, q);
      chk("slave rx word", 16'h000f, q);
      rd(sspt_pkg::OFS_CON, q);
      chk("slave status", (f == 1) ? 16'h8100 : 16'h8000, q & 16'hc100);
    end
    od_sel = 1'b0;
    wr(sspt_pkg::OFS_CON, 16'h0000);
  endtask : t_slave
  // Main sequence
  initial
  begin
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    t_regs();
    t_xfer(1'b0, 1'b0, 1'b1, 4'hf, 16'ha5c3, 16'h9e37, 8'h00);
    t_xfer(1'b0, 1'b1, 1'b0, 4'h1, 16'h0002, 16'h8000, 8'h06);
    t_xfer(1'b1, 1'b0, 1'b1, 4'h7, 16'h00b4, 16'h6c00, 8'h00);
    t_xfer(1'b1, 1'b1, 1'b0, 4'ha, 16'h05d9, 16'hd3a0, 8'h06);
    t_fifo();
    t_slave();
    test_done();
  end
  // Watchdog; the sequence needs about a sixth of this span
  initial
  begin
    #100us;
    n_errors++;
    $display("FAIL watchdog expected finish seen hang");
    test_done();
  end
endmodule : sspt_port_tb
